// ==== verilog/pin_mux_pkg.sv ====
// Constants and types for the shared decoder and SPI pin multiplexer
package pin_mux_pkg;

   // Pad indices within the six-pin group
   localparam int PIN_COUNT = 6;
   localparam int PIN_HOME  = 0;
   localparam int PIN_SPI0_CLOCK_PIN = 1;
   localparam int PIN_SPI0_MASTER_OUT_PIN = 2;
   localparam int PIN_SPI0_MASTER_IN_PIN = 3;
   localparam int PIN_SS0   = 4;
   localparam int PIN_PHA1  = 5;

   // Pull-up enable bit positions in the port pull-up enable words
   localparam int PORTC_BIT_HOME  = 7;
   localparam int PORTC_BIT_PHA1  = 0;
   localparam int PORTE_BIT_SPI0_CLOCK_PIN = 4;
   localparam int PORTE_BIT_SPI0_MASTER_OUT_PIN = 5;
   localparam int PORTE_BIT_SPI0_MASTER_IN_PIN = 6;
   localparam int PORTE_BIT_SS0   = 7;

   // Port E general-purpose select bit positions, one per SPI-0 pin
   localparam int SEL_SPI0_CLOCK_PIN = 0;
   localparam int SEL_SPI0_MASTER_OUT_PIN = 1;
   localparam int SEL_SPI0_MASTER_IN_PIN = 2;
   localparam int SEL_SS0   = 3;

   // Reset values
   localparam logic [PIN_COUNT-1:0] PULLUP_RESET    = 6'h3F;
   localparam logic [PIN_COUNT-1:0] PAD_IN_RESET    = 6'h3F;
   localparam logic [3:0]           PORTE_GPIO_RESET = 4'h0;
   localparam logic                 PHA_ALT_RESET   = 1'b0;

   // Function of the decoder-0 home pin
   typedef enum logic [1:0] {
      HOME_DECODER = 2'h0,
      HOME_TIMER   = 2'h1,
      HOME_GPIO    = 2'h3
   } homeFunc_t;
   localparam logic [1:0] HOME_CODE_ILLEGAL = 2'h2;

   // Function of the decoder-1 phase-A pin while its alternate select is clear
   typedef enum logic [1:0] {
      PHA_DECODER = 2'h0,
      PHA_TIMER   = 2'h1,
      PHA_GPIO    = 2'h3
   } phaFunc_t;
   localparam logic [1:0] PHA_CODE_ILLEGAL = 2'h2;

endpackage : pin_mux_pkg

// ==== verilog/spi_decoder_pin_mux.sv ====
// Pad multiplexer and pull-up control for the decoder and SPI pin group
// Notes on behaviour
// - Home pin resets to decoder; timer, GPIO allowed
// - Port C bit 7 clear drops home pull-up
// - SPI-0 clock drives as master, inputs as slave
// - Four port E pins reset to SPI-0
// - Port E bit 4 clear drops clock pull-up
// - Master-out data leads sampling edge half period
// - Port E bit 5 clear drops master-out pull-up
// - Unselected slave releases master-in line
// - Master-in data leads latching edge half period
// - Port E bit 6 clear drops master-in pull-up
// - Slave select is input, flags addressed transfer
// - Port E bit 7 clear drops select pull-up
// - Phase-A pin reaches SPI-1 clock only when selected
// - Full variant: phase-A pin resets to decoder
// - Port C bit 0 clear drops phase-A pull-up
// - GPIO direction programmable per pin
`timescale 1ns/1ps
`default_nettype none

module spi_decoder_pin_mux
   import pin_mux_pkg::*;
#(
   parameter bit FULL_VARIANT = 1'b1
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // Configuration load
   input  wire logic                 cfgWr,
   input  wire logic [1:0]           cfgHomeFunc,
   input  wire logic [1:0]           cfgPhaseAFunc,
   input  wire logic                 cfgPhaseAAltSelect,
   input  wire logic [3:0]           cfgPortEGpio,
   input  wire logic [7:0]           portCPullupEnable,
   input  wire logic [7:0]           portEPullupEnable,
   // General-purpose I/O, one bit per pad index
   input  wire logic [PIN_COUNT-1:0] gpioDir,
   input  wire logic [PIN_COUNT-1:0] gpioOut,
   output logic      [PIN_COUNT-1:0] gpioIn,
   // Peripheral side
   input  wire logic                 timerA3Out,
   input  wire logic                 timerA3Oe,
   output logic                      timerA3In,
   output logic                      decoder0HomeIn,
   input  wire logic                 spi0Master,
   input  wire logic                 spi0ClkOut,
   input  wire logic                 spi0MosiOut,
   input  wire logic                 spi0MisoOut,
   output logic                      spi0ClkIn,
   output logic                      spi0MosiIn,
   output logic                      spi0MisoIn,
   output logic                      spi0SlaveSelected,
   input  wire logic                 timerB0Out,
   input  wire logic                 timerB0Oe,
   output logic                      timerB0In,
   output logic                      decoder1PhaseAIn,
   input  wire logic                 spi1Master,
   input  wire logic                 spi1ClkOut,
   output logic                      spi1ClkIn,
   // Pads
   input  wire logic [PIN_COUNT-1:0] padIn,
   output logic      [PIN_COUNT-1:0] padOut,
   output logic      [PIN_COUNT-1:0] padOe,
   output logic      [PIN_COUNT-1:0] padPullup
);

   function automatic logic pick(input logic useGpio, input logic gpioBit, input logic altBit);
      return useGpio ? gpioBit : altBit;
   endfunction : pick

   homeFunc_t             homeFunc_reg;
   phaFunc_t              phaFunc_reg;
   logic                  phaAlt_reg;
   logic [3:0]            portEGpio_reg;
   logic [PIN_COUNT-1:0]  pullup_reg;
   logic                  cfgSeen_reg;
   logic [PIN_COUNT-1:0]  sync1_reg;
   logic [PIN_COUNT-1:0]  sync2_reg;
   logic [PIN_COUNT-1:0]  sync3_reg;
   logic [PIN_COUNT-1:0]  padVal_reg;
   logic [PIN_COUNT-1:0]  padOut_reg;
   logic [PIN_COUNT-1:0]  padOe_reg;
   logic [PIN_COUNT-1:0]  gpioIn_reg;
   logic                  timerA3In_reg;
   logic                  homeIn_reg;
   logic                  spi0ClkIn_reg;
   logic                  spi0MosiIn_reg;
   logic                  spi0MisoIn_reg;
   logic                  spi0Sel_reg;
   logic                  timerB0In_reg;
   logic                  phaIn_reg;
   logic                  spi1ClkIn_reg;

   // Illegal codes leave the current function in place
   wire        homeLegal   = (cfgHomeFunc != HOME_CODE_ILLEGAL);
   wire        phaLegal    = (cfgPhaseAFunc != PHA_CODE_ILLEGAL);
   wire [1:0]  homeFunc_next = (cfgWr && homeLegal) ? cfgHomeFunc : homeFunc_reg;
   wire [1:0]  phaFunc_next  = (cfgWr && phaLegal) ? cfgPhaseAFunc : phaFunc_reg;
   wire        phaAlt_next   = cfgWr ? cfgPhaseAAltSelect : phaAlt_reg;
   wire [3:0]  portEGpio_next = cfgWr ? cfgPortEGpio : portEGpio_reg;

   wire [PIN_COUNT-1:0] pullup_next = cfgWr ? {
      portCPullupEnable[PORTC_BIT_PHA1],
      portEPullupEnable[PORTE_BIT_SS0],
      portEPullupEnable[PORTE_BIT_SPI0_MASTER_IN_PIN],
      portEPullupEnable[PORTE_BIT_SPI0_MASTER_OUT_PIN],
      portEPullupEnable[PORTE_BIT_SPI0_CLOCK_PIN],
      portCPullupEnable[PORTC_BIT_HOME]
   } : pullup_reg;

   // A change counts only once the second and third stages agree
   wire [PIN_COUNT-1:0] padVal_next =
      (padVal_reg & ~(sync2_reg ^ sync3_reg)) ^ ((sync2_reg ^ padVal_reg) & ~(sync2_reg ^ sync3_reg))
      | (padVal_reg & (sync2_reg ^ sync3_reg));

   // Function decode
   wire homeGpio  = (homeFunc_reg == HOME_GPIO);
   wire homeTimer = (homeFunc_reg == HOME_TIMER);
   wire homeDec   = (homeFunc_reg == HOME_DECODER);
   wire sclkGpio  = portEGpio_reg[SEL_SPI0_CLOCK_PIN];
   wire mosiGpio  = portEGpio_reg[SEL_SPI0_MASTER_OUT_PIN];
   wire misoGpio  = portEGpio_reg[SEL_SPI0_MASTER_IN_PIN];
   wire ssGpio    = portEGpio_reg[SEL_SS0];
   wire phaSpi    = phaAlt_reg;
   wire phaGpio   = !phaAlt_reg && (phaFunc_reg == PHA_GPIO);
   wire phaTimer  = !phaAlt_reg && (phaFunc_reg == PHA_TIMER);
   wire phaDec    = !phaAlt_reg && (phaFunc_reg == PHA_DECODER) && FULL_VARIANT;

   // Select is active low; only the slave uses it
   wire ssAsserted = !ssGpio && !padVal_reg[PIN_SS0];
   wire misoDrive  = !spi0Master && ssAsserted;

   wire [PIN_COUNT-1:0] padOe_next = {
      pick(phaGpio, gpioDir[PIN_PHA1], phaSpi ? spi1Master : (phaTimer & timerB0Oe)),
      pick(ssGpio, gpioDir[PIN_SS0], 1'b0),
      pick(misoGpio, gpioDir[PIN_SPI0_MASTER_IN_PIN], misoDrive),
      pick(mosiGpio, gpioDir[PIN_SPI0_MASTER_OUT_PIN], spi0Master),
      pick(sclkGpio, gpioDir[PIN_SPI0_CLOCK_PIN], spi0Master),
      pick(homeGpio, gpioDir[PIN_HOME], homeTimer & timerA3Oe)
   };

   // Clock and data share one register stage so their half-period skew survives
   wire [PIN_COUNT-1:0] padOut_next = {
      pick(phaGpio, gpioOut[PIN_PHA1], phaSpi ? spi1ClkOut : (phaTimer & timerB0Out)),
      pick(ssGpio, gpioOut[PIN_SS0], 1'b0),
      pick(misoGpio, gpioOut[PIN_SPI0_MASTER_IN_PIN], spi0MisoOut),
      pick(mosiGpio, gpioOut[PIN_SPI0_MASTER_OUT_PIN], spi0MosiOut),
      pick(sclkGpio, gpioOut[PIN_SPI0_CLOCK_PIN], spi0ClkOut),
      pick(homeGpio, gpioOut[PIN_HOME], homeTimer & timerA3Out)
   };

   wire [PIN_COUNT-1:0] gpioSel = {phaGpio, ssGpio, misoGpio, mosiGpio, sclkGpio, homeGpio};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         homeFunc_reg  <= HOME_DECODER;
         phaFunc_reg   <= PHA_DECODER;
         phaAlt_reg    <= PHA_ALT_RESET;
         portEGpio_reg <= PORTE_GPIO_RESET;
         pullup_reg    <= PULLUP_RESET;
         cfgSeen_reg   <= 1'b0;
      end else begin
         homeFunc_reg  <= homeFunc_t'(homeFunc_next);
         phaFunc_reg   <= phaFunc_t'(phaFunc_next);
         phaAlt_reg    <= phaAlt_next;
         portEGpio_reg <= portEGpio_next;
         pullup_reg    <= pullup_next;
         cfgSeen_reg   <= cfgSeen_reg | cfgWr;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg  <= PAD_IN_RESET;
         sync2_reg  <= PAD_IN_RESET;
         sync3_reg  <= PAD_IN_RESET;
         padVal_reg <= PAD_IN_RESET;
      end else begin
         sync1_reg  <= padIn;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         padVal_reg <= padVal_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         padOut_reg <= '0;
         padOe_reg  <= '0;
      end else begin
         padOut_reg <= padOut_next;
         padOe_reg  <= padOe_next;
      end
   end

   // Deselected functions see a quiet low input
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gpioIn_reg     <= '0;
         timerA3In_reg  <= 1'b0;
         homeIn_reg     <= 1'b0;
         spi0ClkIn_reg  <= 1'b0;
         spi0MosiIn_reg <= 1'b0;
         spi0MisoIn_reg <= 1'b0;
         spi0Sel_reg    <= 1'b0;
         timerB0In_reg  <= 1'b0;
         phaIn_reg      <= 1'b0;
         spi1ClkIn_reg  <= 1'b0;
      end else begin
         gpioIn_reg     <= padVal_reg & gpioSel;
         timerA3In_reg  <= homeTimer & padVal_reg[PIN_HOME];
         homeIn_reg     <= homeDec & padVal_reg[PIN_HOME];
         spi0ClkIn_reg  <= !sclkGpio & padVal_reg[PIN_SPI0_CLOCK_PIN];
         spi0MosiIn_reg <= !mosiGpio & padVal_reg[PIN_SPI0_MASTER_OUT_PIN];
         spi0MisoIn_reg <= !misoGpio & padVal_reg[PIN_SPI0_MASTER_IN_PIN];
         spi0Sel_reg    <= !spi0Master & ssAsserted;
         timerB0In_reg  <= phaTimer & padVal_reg[PIN_PHA1];
         phaIn_reg      <= phaDec & padVal_reg[PIN_PHA1];
         spi1ClkIn_reg  <= phaSpi & padVal_reg[PIN_PHA1];
      end
   end

   assign gpioIn            = gpioIn_reg;
   assign timerA3In         = timerA3In_reg;
   assign decoder0HomeIn    = homeIn_reg;
   assign spi0ClkIn         = spi0ClkIn_reg;
   assign spi0MosiIn        = spi0MosiIn_reg;
   assign spi0MisoIn        = spi0MisoIn_reg;
   assign spi0SlaveSelected = spi0Sel_reg;
   assign timerB0In         = timerB0In_reg;
   assign decoder1PhaseAIn  = phaIn_reg;
   assign spi1ClkIn         = spi1ClkIn_reg;
   assign padOut            = padOut_reg;
   assign padOe             = padOe_reg;
   assign padPullup         = pullup_reg;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_cfgLoad;
      cfgWr;
   endsequence

   a_home_default: assert property (!cfgSeen_reg |-> homeFunc_reg == HOME_DECODER)
      else $error("home pin left decoder before any load");
   a_pullup_home: assert property (s_cfgLoad |=> padPullup[PIN_HOME] == $past(portCPullupEnable[7]))
      else $error("home pull-up does not follow port C bit 7");
   a_sclk_dir: assert property (!sclkGpio |=> padOe[PIN_SPI0_CLOCK_PIN] == $past(spi0Master))
      else $error("clock pin direction wrong for mode");
   a_porte_default: assert property (!cfgSeen_reg |-> portEGpio_reg == PORTE_GPIO_RESET)
      else $error("port E pins not on SPI after reset");
   a_pullup_sclk: assert property (s_cfgLoad |=> padPullup[PIN_SPI0_CLOCK_PIN] == $past(portEPullupEnable[4]))
      else $error("clock pull-up does not follow port E bit 4");
   a_mosi_align: assert property (!mosiGpio && !sclkGpio && spi0Master
         |=> padOut[PIN_SPI0_MASTER_OUT_PIN] == $past(spi0MosiOut) && padOut[PIN_SPI0_CLOCK_PIN] == $past(spi0ClkOut))
      else $error("master-out and clock lost alignment");
   a_pullup_mosi: assert property (s_cfgLoad |=> padPullup[PIN_SPI0_MASTER_OUT_PIN] == $past(portEPullupEnable[5]))
      else $error("master-out pull-up does not follow port E bit 5");
   a_miso_release: assert property (!misoGpio && (spi0Master || !ssAsserted) |=> !padOe[PIN_SPI0_MASTER_IN_PIN])
      else $error("unselected slave drives master-in");
   a_miso_align: assert property (!misoGpio && misoDrive |=> padOe[PIN_SPI0_MASTER_IN_PIN] && padOut[PIN_SPI0_MASTER_IN_PIN] == $past(spi0MisoOut))
      else $error("selected slave data not on master-in");
   a_pullup_miso: assert property (s_cfgLoad |=> padPullup[PIN_SPI0_MASTER_IN_PIN] == $past(portEPullupEnable[6]))
      else $error("master-in pull-up does not follow port E bit 6");
   a_ss_input: assert property (!ssGpio |=> !padOe[PIN_SS0] && spi0SlaveSelected == $past(!spi0Master && !padVal_reg[PIN_SS0]))
      else $error("slave select driven or misreported");
   a_pullup_ss: assert property (s_cfgLoad |=> padPullup[PIN_SS0] == $past(portEPullupEnable[7]))
      else $error("select pull-up does not follow port E bit 7");
   a_spi1_gate: assert property (!phaAlt_reg |=> !spi1ClkIn)
      else $error("SPI-1 clock reached without alternate select");
   a_pha_default: assert property (!cfgSeen_reg |-> phaFunc_reg == PHA_DECODER && !phaAlt_reg)
      else $error("phase-A pin not on decoder after reset");
   a_pullup_pha: assert property (s_cfgLoad |=> padPullup[PIN_PHA1] == $past(portCPullupEnable[0]))
      else $error("phase-A pull-up does not follow port C bit 0");
   a_gpio_dir: assert property (homeGpio |=> padOe[PIN_HOME] == $past(gpioDir[PIN_HOME]))
      else $error("home pin GPIO direction not honoured");
   a_pullup_reset: assert property (!cfgSeen_reg |-> padPullup == PULLUP_RESET)
      else $error("pull-ups not enabled after reset");

endmodule : spi_decoder_pin_mux

`default_nettype wire

// ==== verification/pad_peer_model.sv ====
// Far-side pad model: SPI peers, encoder and GPIO loads on the six pads
`timescale 1ns/1ps
`default_nettype none

module pad_peer_model
   import pin_mux_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic [PIN_COUNT-1:0] padOut,
   input  wire logic [PIN_COUNT-1:0] padOe,
   input  wire logic [PIN_COUNT-1:0] padPullup,
   input  wire logic [PIN_COUNT-1:0] peerEn,
   input  wire logic [PIN_COUNT-1:0] peerVal,
   input  wire logic                 peerSelected,
   output logic      [PIN_COUNT-1:0] padIn
);
   logic [PIN_COUNT-1:0] lastReg;
   logic [PIN_COUNT-1:0] peerDrive;

   initial lastReg = '0;

   always_comb begin
      peerDrive = peerEn;
      peerDrive[PIN_SPI0_MASTER_IN_PIN] = peerEn[PIN_SPI0_MASTER_IN_PIN] & peerSelected;
   end

   // Floating unpulled pad toggles so a stale level never passes as valid
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (padOe[i])
            padIn[i] = padOut[i];
         else if (peerDrive[i])
            padIn[i] = peerVal[i];
         else if (padPullup[i])
            padIn[i] = 1'b1;
         else
            padIn[i] = ~lastReg[i];
      end
   end

   always @(posedge mclk) lastReg <= padIn;
endmodule : pad_peer_model
`default_nettype wire

// ==== verification/spi_decoder_pin_mux_test.sv ====
// Self-checking bench for the decoder and SPI pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module spi_decoder_pin_mux_test
   import pin_mux_pkg::*;
;
   logic       mclk, rst_n, cfgWr, cfgPhaseAAltSelect, peerSel;
   logic       timerA3Out, timerA3Oe, timerA3In, decoder0HomeIn, spi0Master;
   logic       spi0ClkOut, spi0MosiOut, spi0MisoOut, spi0ClkIn, spi0MosiIn, spi0MisoIn;
   logic       spi0SlaveSelected, timerB0Out, timerB0Oe, timerB0In, decoder1PhaseAIn;
   logic       spi1Master, spi1ClkOut, spi1ClkIn;
   logic [1:0] cfgHomeFunc, cfgPhaseAFunc;
   logic [3:0] cfgPortEGpio;
   logic [7:0] portCPullupEnable, portEPullupEnable;
   logic [5:0] gpioDir, gpioOut, gpioIn, padIn, padOut, padOe, padPullup, peerVal;
   int         mismatches, total_checks;

   spi_decoder_pin_mux #(.FULL_VARIANT(1'b1)) u_spi_decoder_pin_mux (.mclk, .rst_n,
      .cfgWr, .cfgHomeFunc, .cfgPhaseAFunc, .cfgPhaseAAltSelect, .cfgPortEGpio,
      .portCPullupEnable, .portEPullupEnable, .gpioDir, .gpioOut, .gpioIn,
      .timerA3Out, .timerA3Oe, .timerA3In, .decoder0HomeIn, .spi0Master, .spi0ClkOut,
      .spi0MosiOut, .spi0MisoOut, .spi0ClkIn, .spi0MosiIn, .spi0MisoIn, .spi0SlaveSelected,
      .timerB0Out, .timerB0Oe, .timerB0In, .decoder1PhaseAIn, .spi1Master, .spi1ClkOut,
      .spi1ClkIn, .padIn, .padOut, .padOe, .padPullup);

   pad_peer_model u_pad_peer_model (.mclk, .padOut, .padOe, .padPullup,
      .peerEn(6'h3F), .peerVal, .peerSelected(peerSel), .padIn);

   always #50 mclk = ~mclk;

   function automatic logic [5:0] exp_pull(input logic [7:0] c, input logic [7:0] e);
      return {c[0], e[7], e[6], e[5], e[4], c[7]};
   endfunction : exp_pull

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : tick

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Pull-up words are random on every load, so each load checks the bit map
   task automatic cfg(input logic [1:0] h, input logic [1:0] pa, input logic alt,
                      input logic [3:0] e);
      logic [7:0] c;
      logic [7:0] p;
      c = $urandom;
      p = $urandom;
      @(posedge mclk);
      {cfgHomeFunc, cfgPhaseAFunc, cfgPhaseAAltSelect, cfgPortEGpio} <= {h, pa, alt, e};
      portCPullupEnable <= c;
      portEPullupEnable <= p;
      cfgWr <= 1'b1;
      @(posedge mclk);
      cfgWr <= 1'b0;
      @(negedge mclk);
      chk("padPullup", {2'h0, exp_pull(c, p)}, {2'h0, padPullup});
      tick(1);
   endtask : cfg

   task automatic reset_seq();
      @(posedge mclk);
      rst_n <= 1'b0;
      spi0Master <= 1'b1;
      tick(3);
      chk("rstPullup", 8'h3F, {2'h0, padPullup});
      chk("rstOe", 8'h00, {2'h0, padOe});
      rst_n <= 1'b1;
      tick(2);
      chk("defaultOe", 8'h06, {2'h0, padOe});
   endtask : reset_seq

   initial begin
      mismatches = 0;
      total_checks = 0;
      repeat (5000) @(posedge mclk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      logic [5:0] v;
      logic [1:0] hc [4];
      int unsigned seedVal;
      hc = '{2'h1, 2'h2, 2'h3, 2'h0};
      seedVal = $urandom(32'hE5ED64CE);
      {mclk, rst_n, cfgWr, cfgPhaseAAltSelect, peerSel, timerA3Out, timerA3Oe} = '0;
      {spi0ClkOut, spi0MosiOut, spi0MisoOut, timerB0Out, timerB0Oe, spi1ClkOut} = '0;
      {cfgHomeFunc, cfgPhaseAFunc, cfgPortEGpio, gpioDir, gpioOut, peerVal} = '0;
      {portCPullupEnable, portEPullupEnable} = 16'hFFFF;
      spi0Master = 1'b1;
      spi1Master = 1'b1;
      reset_seq();
      // Master mode: pad outputs, peer slave answers, encoder inputs reach decoders
      for (int i = 0; i < 12; i++) begin
         cfg(2'h0, 2'h0, 1'b0, 4'h0);
         @(posedge mclk);
         v = $urandom;
         peerVal <= v;
         peerSel <= 1'b1;
         spi0ClkOut <= v[3];
         spi0MosiOut <= v[4];
         tick(1);
         chk("spiOut", {6'h0, v[4], v[3]}, {6'h0, padOut[2:1]});
         tick(5);
         chk("decIn", {6'h0, v[5], v[0]}, {6'h0, decoder1PhaseAIn, decoder0HomeIn});
         chk("misoIn", {7'h0, v[3]}, {7'h0, spi0MisoIn});
         chk("idleIn", 8'h0, {6'h0, timerA3In, spi1ClkIn});
      end
      // Slave mode, selected then not selected
      for (int s = 0; s < 2; s++) begin
         @(posedge mclk);
         v = $urandom;
         v[4] = s[0];
         peerVal <= v;
         peerSel <= 1'b0;
         spi0Master <= 1'b0;
         spi0MisoOut <= v[5];
         tick(6);
         chk("slaveSel", {7'h0, ~s[0]}, {7'h0, spi0SlaveSelected});
         chk("slaveOe", {5'h0, ~s[0], 2'h0}, {5'h0, padOe[3:1]});
         chk("slaveIn", {6'h0, v[2], v[1]}, {6'h0, spi0MosiIn, spi0ClkIn});
         if (s == 0) chk("misoOut", {7'h0, v[5]}, {7'h0, padOut[3]});
      end
      // Home pin functions; code 2 must keep the timer
      @(posedge mclk);
      {timerA3Oe, timerA3Out, gpioDir, gpioOut} <= {2'b11, 6'h21, 6'h00};
      for (int k = 0; k < 4; k++) begin
         cfg(hc[k], 2'h0, 1'b0, 4'h0);
         chk("homeOe", {7'h0, k < 3}, {7'h0, padOe[0]});
         if (k < 3) chk("homeOut", {7'h0, k < 2}, {7'h0, padOut[0]});
      end
      @(posedge mclk);
      spi1ClkOut <= $urandom;
      cfg(2'h0, 2'h0, 1'b1, 4'h0);
      chk("spi1Clk", {6'h0, 1'b1, spi1ClkOut}, {6'h0, padOe[5], padOut[5]});
      cfg(2'h0, 2'h1, 1'b0, 4'h0);
      chk("timerB0Oe", 8'h0, {7'h0, padOe[5]});
      // Pad only reaches the timer once the synchroniser has caught up
      tick(6);
      chk("timerB0In", {7'h0, peerVal[5]}, {7'h0, timerB0In});
      // Every pin as GPIO with its own direction
      @(posedge mclk);
      v = $urandom;
      gpioDir <= v;
      gpioOut <= ~v ^ 6'h15;
      peerSel <= 1'b1;
      cfg(2'h3, 2'h3, 1'b0, 4'hF);
      chk("gpioOe", {2'h0, v}, {2'h0, padOe});
      chk("gpioOut", {2'h0, v & (~v ^ 6'h15)}, {2'h0, padOut & padOe});
      tick(6);
      chk("gpioIn", {2'h0, (v & (~v ^ 6'h15)) | (~v & peerVal)}, {2'h0, gpioIn});
      reset_seq();
      tally_and_finish();
   end
endmodule : spi_decoder_pin_mux_test
`default_nettype wire
